// File: src/acd_pkg.sv
// Package for the aperture delay and sync register slice.
// Assumes APB with 32-bit data; registers sit in the low 16 bits of each word.
package acd_pkg;
  // Printed offsets are not all multiples of four: they are word indices
  localparam logic [3:0]  IDX_COARSE   = 4'hC;
  localparam logic [3:0]  IDX_FINE     = 4'hD;
  localparam logic [3:0]  IDX_SYNC     = 4'hE;
  localparam logic [3:0]  IDX_RSVD     = 4'hF;
  localparam int          ADDR_LSB     = 2;
  localparam int          ADDR_W       = 6;
  localparam int          REG_W        = 16;

  localparam logic [15:0] RST_COARSE   = 16'h0004;
  localparam logic [15:0] RST_FINE     = 16'h0000;
  localparam logic [15:0] RST_SYNC     = 16'h0003;
  localparam logic [15:0] RST_RSVD     = 16'h0018;

  // Field positions
  localparam int          COARSE_MAG_HI = 15;
  localparam int          COARSE_MAG_LO = 4;
  localparam int          ADJ_SEL_BIT   = 3;
  localparam int          DUTY_EN_BIT   = 2;
  localparam int          FINE_MAG_HI   = 15;
  localparam int          FINE_MAG_LO   = 10;
  localparam int          REF_DLY_HI    = 15;
  localparam int          REF_DLY_LO    = 7;
  localparam int          PHASE_HI      = 4;
  localparam int          PHASE_LO      = 3;
  localparam int          SLAVE_BIT     = 2;
  localparam int          REF_OFF_BIT   = 1;
  localparam int          RST_OFF_BIT   = 0;

  // Saturation codes
  localparam logic [11:0] COARSE_MAX   = 12'h97F;
  localparam logic [8:0]  REFDLY_MAX   = 9'h13F;

  // Reference clock output divider
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
endpackage : acd_pkg

// File: src/acd_regs.sv
// Aperture delay, duty stabilizer and multi-device sync register slice.
// Assumes an APB master on core_clk; delay line controls go to analog blocks.
//
// Design decision made here: the APB register port.
module acd_regs
  import acd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              output_clock_reset_in,
  output logic [11:0]            coarse_delay_code,
  output logic [5:0]             fine_delay_code,
  output logic                   aperture_adjust_sel,
  output logic                   duty_stabilizer_en,
  output logic [8:0]             ref_clock_delay,
  output logic [1:0]             ref_phase_sel,
  output logic                   slave_mode_en,
  output logic                   ref_clock_out_a,
  output logic                   ref_clock_out_b,
  output logic                   ref_clock_out_en,
  output logic                   outclk_reset
);

  // Control words as last accepted from the bus
  logic [REG_W-1:0] coarseCtrl_reg;
  logic [REG_W-1:0] fineCtrl_reg;
  logic [REG_W-1:0] syncCtrl_reg;
  logic [REG_W-1:0] rsvdWord_reg;
  logic [1:0]       divCnt_reg;
  logic             pinMeta_reg;
  logic             pinSync_reg;

  // Word index decode, shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    hit = (a[ADDR_W-1:ADDR_LSB] == idx);
  endfunction : hit

  // Byte lane merge, lanes without a strobe keep their old value
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [REG_W-1:0] nw,
                                             input logic [REG_W-1:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Codes past the top step add no more delay
  function automatic logic [11:0] clampCoarse(input logic [11:0] code);
    clampCoarse = (code > COARSE_MAX) ? COARSE_MAX : code;
  endfunction : clampCoarse

  // Reference delay stays at its maximum from the top code on
  function automatic logic [8:0] clampRef(input logic [8:0] code);
    clampRef = (code > REFDLY_MAX) ? REFDLY_MAX : code;
  endfunction : clampRef

  // Bus phase decode
  wire logic              setupPhase  = psel && !penable;
  wire logic              accessPhase = psel && penable;
  wire logic              wrAccess    = accessPhase && pwrite;
  wire logic              selCoarse   = hit(paddr, IDX_COARSE);
  wire logic              selFine     = hit(paddr, IDX_FINE);
  wire logic              selSync     = hit(paddr, IDX_SYNC);
  wire logic              selRsvd     = hit(paddr, IDX_RSVD);
  wire logic              mapped      = selCoarse || selFine || selSync || selRsvd;
  wire logic [REG_W-1:0]  byteMask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Writes land only at the access edge, the one the master completes on
  wire logic              wrCoarse    = wrAccess && selCoarse;
  wire logic              wrFine      = wrAccess && selFine;
  wire logic              wrSync      = wrAccess && selSync;
  wire logic              wrRsvd      = wrAccess && selRsvd;

  wire logic [REG_W-1:0]  coarseCtrl_next = wrCoarse
                                            ? merge(coarseCtrl_reg, pwdata[REG_W-1:0], byteMask)
                                            : coarseCtrl_reg;
  wire logic [REG_W-1:0]  fineCtrl_next   = wrFine
                                            ? merge(fineCtrl_reg, pwdata[REG_W-1:0], byteMask)
                                            : fineCtrl_reg;
  wire logic [REG_W-1:0]  syncCtrl_next   = wrSync
                                            ? merge(syncCtrl_reg, pwdata[REG_W-1:0], byteMask)
                                            : syncCtrl_reg;
  wire logic [REG_W-1:0]  rsvdWord_next   = wrRsvd
                                            ? merge(rsvdWord_reg, pwdata[REG_W-1:0], byteMask)
                                            : rsvdWord_reg;

  // Reserved bits stored as written; keeping them clean is the host's job
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      coarseCtrl_reg <= RST_COARSE;
    end
    else
    begin
      coarseCtrl_reg <= coarseCtrl_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fineCtrl_reg <= RST_FINE;
    end
    else
    begin
      fineCtrl_reg <= fineCtrl_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      syncCtrl_reg <= RST_SYNC;
    end
    else
    begin
      syncCtrl_reg <= syncCtrl_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rsvdWord_reg <= RST_RSVD;
    end
    else
    begin
      rsvdWord_reg <= rsvdWord_next;
    end
  end

  // Read data picked in setup, so it stands with pready in the access cycle
  wire logic [REG_W-1:0]  rdSel  = selCoarse ? coarseCtrl_reg :
                                   selFine   ? fineCtrl_reg   :
                                   selSync   ? syncCtrl_reg   :
                                   selRsvd   ? rsvdWord_reg   : 16'h0000;
  wire logic [31:0]       rdWord = {16'h0000, rdSel};

  // No wait state: pready is raised for the access cycle only
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setupPhase;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= setupPhase && !mapped;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= (setupPhase && !pwrite) ? rdWord : 32'h0000_0000;
    end
  end

  // Fields of the stored words
  wire logic [11:0] coarseMag = coarseCtrl_reg[COARSE_MAG_HI:COARSE_MAG_LO];
  wire logic [5:0]  fineMag   = fineCtrl_reg[FINE_MAG_HI:FINE_MAG_LO];
  wire logic [8:0]  refDelay  = syncCtrl_reg[REF_DLY_HI:REF_DLY_LO];
  wire logic        adjustOn  = coarseCtrl_reg[ADJ_SEL_BIT];
  wire logic        refOutOn  = !syncCtrl_reg[REF_OFF_BIT];
  wire logic        rstGateOn = !syncCtrl_reg[RST_OFF_BIT];

  // Next values of the registered controls
  wire logic [11:0] coarseDelay_next = adjustOn ? clampCoarse(coarseMag) : 12'h000;
  wire logic [5:0]  fineDelay_next   = adjustOn ? fineMag : 6'h00;
  wire logic        adjustSel_next   = adjustOn;
  wire logic        dutyEn_next      = coarseCtrl_reg[DUTY_EN_BIT];
  wire logic [8:0]  refDelay_next    = clampRef(refDelay);
  wire logic [1:0]  phaseSel_next    = syncCtrl_reg[PHASE_HI:PHASE_LO];
  wire logic        slaveMode_next   = syncCtrl_reg[SLAVE_BIT];
  wire logic        refClkA_next     = refOutOn && divCnt_reg[1];
  wire logic        refClkB_next     = refOutOn && divCnt_reg[1];
  wire logic        refOutEn_next    = refOutOn;
  wire logic        outclkRst_next   = rstGateOn && pinSync_reg;

  // Stand-in for the sampling clock divider; free running by design
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      divCnt_reg <= 2'h0;
    end
    else
    begin
      divCnt_reg <= divCnt_reg + 2'h1;
    end
  end

  // Pin input, two flops; only the second is read
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pinMeta_reg <= 1'b0;
    else
      pinMeta_reg <= output_clock_reset_in;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pinSync_reg <= 1'b0;
    else
      pinSync_reg <= pinMeta_reg;
  end

  // Controls are registered so the analog side sees no glitch
  // Aperture delay
  always_ff @(posedge core_clk)
  begin
    if (srst)
      coarse_delay_code <= 12'h000;
    else
      coarse_delay_code <= coarseDelay_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      fine_delay_code <= 6'h00;
    else
      fine_delay_code <= fineDelay_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      aperture_adjust_sel <= 1'b0;
    else
      aperture_adjust_sel <= adjustSel_next;
  end

  // Duty stabilizer, on out of reset
  always_ff @(posedge core_clk)
  begin
    if (srst)
      duty_stabilizer_en <= 1'b1;
    else
      duty_stabilizer_en <= dutyEn_next;
  end

  // Reference clock input path
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ref_clock_delay <= 9'h000;
    else
      ref_clock_delay <= refDelay_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ref_phase_sel <= 2'h0;
    else
      ref_phase_sel <= phaseSel_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      slave_mode_en <= 1'b0;
    else
      slave_mode_en <= slaveMode_next;
  end

  // Reference clock outputs; mode is ignored on purpose
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ref_clock_out_a <= 1'b0;
    else
      ref_clock_out_a <= refClkA_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ref_clock_out_b <= 1'b0;
    else
      ref_clock_out_b <= refClkB_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ref_clock_out_en <= 1'b0;
    else
      ref_clock_out_en <= refOutEn_next;
  end

  // Output clock reset, gated pin
  always_ff @(posedge core_clk)
  begin
    if (srst)
      outclk_reset <= 1'b0;
    else
      outclk_reset <= outclkRst_next;
  end

endmodule : acd_regs

// File: dv/acd_regs_asserts.sv
// Checker for the aperture delay and sync register slice.
// Bound to acd_regs; sees its ports only, one clock domain.
module acd_regs_asserts
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] coarse_delay_code,
  input wire logic        aperture_adjust_sel,
  input wire logic [1:0]  ref_phase_sel,
  input wire logic        ref_clock_out_a,
  input wire logic        ref_clock_out_b,
  input wire logic        ref_clock_out_en,
  input wire logic        outclk_reset,
  input wire logic        output_clock_reset_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic wrDone = psel & penable & pready & pwrite;
  // Disabling the outputs may cut a half period short
  sequence s_hold; ref_clock_out_a || !ref_clock_out_en; endsequence
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_sat; aperture_adjust_sel |-> coarse_delay_code <= 12'h97F; endproperty
  a_sat: assert property (p_sat) else $error("coarse code above maximum");
  property p_sel; !aperture_adjust_sel |-> coarse_delay_code == 12'h000; endproperty
  a_sel: assert property (p_sel) else $error("coarse delay without select");
  property p_off; !ref_clock_out_en |-> !ref_clock_out_a && !ref_clock_out_b; endproperty
  a_off: assert property (p_off) else $error("reference output while off");
  property p_ab; ref_clock_out_a == ref_clock_out_b; endproperty
  a_ab: assert property (p_ab) else $error("reference outputs differ");
  property p_wave; $rose(ref_clock_out_a) |=> s_hold ##1 (!ref_clock_out_a || !ref_clock_out_en);
  endproperty
  a_wave: assert property (p_wave) else $error("reference output not div4");
  property p_rst; $rose(outclk_reset) |-> $past(output_clock_reset_in, 3); endproperty
  a_rst: assert property (p_rst) else $error("output reset without pin");
  property p_chg; $changed(ref_phase_sel) |-> $past(wrDone) || $past(wrDone, 2); endproperty
  a_chg: assert property (p_chg) else $error("phase changed without write");
endmodule : acd_regs_asserts

// File: dv/acd_pin_src.sv
// Board-side source of the output clock reset pin.
// Assumes one request pulse from the bench per event.
module acd_pin_src
(
  input  wire logic core_clk,
  input  wire logic fire,
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left = 3'h0;
  // Four cycles wide so the two-flop synchroniser cannot miss it
  assign pinLevel = (left != 3'h0);
  always @(posedge core_clk)
    left <= fire ? 3'h4 : (left != 3'h0) ? left - 3'h1 : 3'h0;
endmodule : acd_pin_src

// File: dv/test_acd_regs.sv
// Bench for the aperture delay and sync register slice.
// Assumes APB access answered by pready; one clock, sync reset.
module test_acd_regs
  import acd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, errv, pinLevel, aperture_adjust_sel, duty_stabilizer_en;
  logic slave_mode_en, ref_clock_out_a, ref_clock_out_b, ref_clock_out_en, outclk_reset;
  logic [11:0] coarse_delay_code;
  logic [5:0] fine_delay_code;
  logic [8:0] ref_clock_delay;
  logic [1:0] ref_phase_sel;
  int err_total = 0, samples_checked = 0;
  acd_regs i_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .pready, .prdata, .pslverr, .output_clock_reset_in(pinLevel), .coarse_delay_code,
    .fine_delay_code, .aperture_adjust_sel, .duty_stabilizer_en, .ref_clock_delay,
    .ref_phase_sel, .slave_mode_en, .ref_clock_out_a, .ref_clock_out_b, .ref_clock_out_en,
    .outclk_reset);
  acd_pin_src i_pin (.core_clk, .fire, .pinLevel);
  initial
    forever #20 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [15:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : apb
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  logic [15:0] rv [4] = '{16'h0004, 16'h0000, 16'h0003, 16'h0018};
  logic [15:0] cw [4] = '{16'hFFF8, 16'h97FC, 16'h9808, 16'h0018};
  logic [11:0] ce [4] = '{12'h97F, 12'h97F, 12'h97F, 12'h001};
  initial
  begin
    logic [15:0] sw;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(duty_stabilizer_en, 1, "dcc");
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 4'hC + 4'(i), 16'h0000);
      check(rdv, {16'h0000, rv[i]}, "reset");
    end
    apb(0, 4'h0, 16'h0000);
    check(errv, 1, "unmapped error");
    check(rdv, 0, "unmapped data");
    for (int i = 0; i < 4; i++)
    begin
      apb(1, 4'hC, cw[i]);
      check(coarse_delay_code, ce[i], "coarse");
      check({aperture_adjust_sel, duty_stabilizer_en}, cw[i][3:2], "sel dcc");
    end
    apb(1, 4'hD, 16'hFC00);
    check(fine_delay_code, 6'h3F, "fine");
    apb(1, 4'hC, 16'h97F4);
    check({coarse_delay_code, fine_delay_code}, 18'h0, "adjust off");
    for (int p = 0; p < 4; p++)
    begin
      sw = {9'h13E + 9'(p), 2'b00, 2'(p), p[1], p[0], 1'b1};
      apb(1, 4'hE, sw);
      apb(0, 4'hE, 16'h0000);
      check(rdv, {16'h0000, sw}, "sync");
      check(ref_clock_delay, (p < 1) ? 9'h13E : 9'h13F, "rdelay");
      check({ref_phase_sel, slave_mode_en}, {2'(p), p[1]}, "phase");
      check(ref_clock_out_en, !p[0], "ref out");
    end
    for (int d = 0; d < 2; d++)
    begin
      apb(1, 4'hE, {15'h0001, 1'(d)});
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (5) @(posedge core_clk);
      check(outclk_reset, !d, "outclk reset");
    end
    wrap_up();
  end
  initial
  begin
    #40000;
    err_total++;
    wrap_up();
  end
endmodule : test_acd_regs
bind acd_regs acd_regs_asserts u_chk (.core_clk, .srst, .psel, .penable, .pwrite, .pready,
  .coarse_delay_code, .aperture_adjust_sel, .ref_phase_sel, .ref_clock_out_a, .ref_clock_out_b,
  .ref_clock_out_en, .outclk_reset, .output_clock_reset_in);
